// ---- pss_delay_timer.sv ----
// one-shot cycle timer used for the bias reset and hiccup waits
// assumes the caller pulses start on entering the waiting state
`timescale 1ns/100ps
module pss_delay_timer #(
    parameter int COUNT = 4000
) (
    // clock and reset
    input wire logic clock_i,
    input wire logic rst_n_i,
    // control
    input wire logic start_i,
    input wire logic run_i,
    // status
    output logic done_o
);
    if (COUNT < 1) begin : g_chk
        $error("pss_delay_timer: COUNT must be at least one");
    end

    localparam int W = $clog2(COUNT + 1);
    localparam logic [W-1:0] LOAD = W'(COUNT);

    logic [W-1:0] cnt_q;
    logic [W-1:0] cnt_d;

    // reload on start, count down while running, stop at zero
    always_comb begin
        cnt_d = cnt_q;
        if (start_i) begin
            cnt_d = LOAD;
        end else if (run_i && cnt_q != '0) begin
            cnt_d = cnt_q - W'(1);
        end
    end

    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            cnt_q <= '0;
        end else begin
            cnt_q <= cnt_d;
        end
    end

    assign done_o = run_i && !start_i && cnt_q == '0;
endmodule // pss_delay_timer

// ---- pss_pkg.sv ----
// package of the power state sequencer: states, config byte layout, event carrier
// assumes one 40 MHz clock and synchronous supervisor inputs
package pss_pkg;
    // configuration byte address and layout
    localparam logic [7:0] PSS_CFG_ADDR = 8'h0f;
    localparam logic [7:0] PSS_CFG_RESET = 8'h9e;
    localparam int PSS_FULL_DUTY_BIT = 7;
    localparam int PSS_SPREAD_BIT = 6;
    localparam int PSS_CONT_COND_BIT = 5;
    localparam int PSS_HIGH_DRV_MSB = 4;
    localparam int PSS_HIGH_DRV_LSB = 3;
    localparam int PSS_LOW_DRV_MSB = 2;
    localparam int PSS_LOW_DRV_LSB = 1;
    localparam logic [7:0] PSS_CFG_WMASK = 8'hfe;
    localparam logic [1:0] PSS_DRIVE_LOW_NOISE = 2'h0;
    localparam logic [1:0] PSS_DRIVE_EFFICIENT = 2'h3;

    // bias reset delay and auto-restart hiccup wait
    localparam int PSS_CLK_HZ = 40000000;
    localparam int PSS_RESET_DELAY_US = 100;
    localparam int PSS_RESET_DELAY_CYC = (PSS_CLK_HZ / 1000000) * PSS_RESET_DELAY_US;
    localparam int PSS_HICCUP_US = 1000;
    localparam int PSS_HICCUP_CYC = (PSS_CLK_HZ / 1000000) * PSS_HICCUP_US;

    typedef enum logic [3:0] {
        PSS_NO_POWER     = 4'h0,
        PSS_BIAS_RAMP    = 4'h1,
        PSS_FREQ_CHECK   = 4'h2,
        PSS_BIAS_READY   = 4'h3,
        PSS_PRIMARY_RAMP = 4'h4,
        PSS_PRIMARY_ON   = 4'h5,
        PSS_SERVO        = 4'h6,
        PSS_BIAS_RESET   = 4'h7,
        PSS_SHUTDOWN     = 4'h8,
        PSS_AUTO_RESTART = 4'h9
    } pss_state_t;

    // supervisor events, all level inputs sampled each clock
    typedef struct packed {
        logic power_present;
        logic input_undervoltage_lockout;
        logic input_overvoltage_lockout;
        logic bias_converter_up;
        logic freq_resistor_valid;
        logic freq_resistor_out_of_range;
        logic bias_converter_fault;
        logic aux_undervoltage_fault;
        logic hard_thermal_shutdown;
        logic output_rising;
        logic latch_undervoltage_fault;
        logic latch_sync_error;
        logic output_overvoltage_fault;
        logic output_overcurrent_fault;
        logic hiccup_undervoltage_fault;
        logic hiccup_sync_error;
        logic soft_thermal_shutdown;
        logic servo_complete;
        logic shutdown_complete;
    } pss_events_t;

    // bias converter settings from the configuration byte
    typedef struct packed {
        logic full_duty;
        logic spread_spectrum;
        logic continuous_conduction;
        logic [1:0] high_side_drive_strength;
        logic [1:0] low_side_drive_strength;
    } pss_bias_cfg_t;
endpackage

// ---- pss_sequencer.sv ----
// supervisory state machine of the step-down converter plus its bias configuration byte
// assumes synchronous supervisor inputs and a byte-wide register port from the serial slave
`timescale 1ns/100ps
module pss_sequencer
    import pss_pkg::*;
#(
    parameter int RESET_DELAY_CYC = PSS_RESET_DELAY_CYC,
    parameter int HICCUP_CYC = PSS_HICCUP_CYC
)
// Operation
// - config bit 7 enables full-duty bias converter operation; resets to one
// - config bit 6 enables bias converter spread spectrum; resets to zero
// - config bit 5 selects forced continuous conduction, else pulse skipping; resets zero
// - bits 4:3 high-side drive: 00 low noise, 11 efficient default; never 01/10
// - bits 2:1 low-side drive: 00 low noise, 11 efficient default; never 01/10
// - power loss or input lockouts force no-power; power attach goes to bias ramp
// - bias ramp moves to frequency check once the bias converter is up
// - bias ready holds bias-good high; rising enable starts primary ramp
// - primary ramp goes to primary on when output-good rises
// - primary on: a target register change enters servo
// - servo ends on servo completion, returning to primary on
// - bias faults enter bias reset; reset delay timeout returns to bias ramp
// - with enable high, latch-off faults or falling internal enable enter shutdown; done goes bias ready
// - with enable high, hiccup faults enter auto-restart; timeout ramps, falling internal enable readies
// - register accesses are taken only while bias-good is high
(
    // clock and reset
    input wire logic clock_i,
    input wire logic rst_n_i,
    // supervisor events and enable
    input wire pss_events_t events_i,
    input wire logic enable_i,
    input wire logic internal_converter_enable_i,
    input wire logic target_change_i,
    // register port
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    input wire logic [7:0] reg_addr_i,
    input wire logic [7:0] reg_wdata_i,
    output logic [7:0] reg_rdata_o,
    output logic reg_ack_o,
    // state and indicators
    output pss_state_t state_o,
    output logic bias_good_indicator_o,
    output logic output_good_indicator_o,
    output logic primary_enable_o,
    output pss_bias_cfg_t bias_cfg_o
);
    pss_state_t state_q;
    pss_state_t state_d;
    logic en_q;
    logic int_en_q;
    logic out_q;
    logic [7:0] cfg_q;
    logic [7:0] cfg_d;
    logic [7:0] rdata_q;
    logic [7:0] rdata_d;
    logic ack_q;
    logic ack_d;
    logic reset_done;
    logic hiccup_done;
    logic en_rise;
    logic int_en_fall;
    logic out_rise;
    logic bias_good;

    // drive pairs 01/10 are illegal; fold them to the efficient code so stages stay safe
    function automatic logic [1:0] pss_drive(input logic [1:0] code);
        return (code == PSS_DRIVE_LOW_NOISE) ? PSS_DRIVE_LOW_NOISE : PSS_DRIVE_EFFICIENT;
    endfunction

    assign en_rise = enable_i && !en_q;
    assign int_en_fall = !internal_converter_enable_i && int_en_q;
    assign out_rise = events_i.output_rising && !out_q;

    // timers run only in their waiting states and reload on entry
    pss_delay_timer #(.COUNT(RESET_DELAY_CYC)) u_reset_timer (
        .clock_i(clock_i),
        .rst_n_i(rst_n_i),
        .start_i(state_d == PSS_BIAS_RESET && state_q != PSS_BIAS_RESET),
        .run_i(state_q == PSS_BIAS_RESET),
        .done_o(reset_done)
    );

    pss_delay_timer #(.COUNT(HICCUP_CYC)) u_hiccup_timer (
        .clock_i(clock_i),
        .rst_n_i(rst_n_i),
        .start_i(state_d == PSS_AUTO_RESTART && state_q != PSS_AUTO_RESTART),
        .run_i(state_q == PSS_AUTO_RESTART),
        .done_o(hiccup_done)
    );

    // next state with fixed cause priority
    always_comb begin
        logic normal;
        logic bias_fault;
        logic latch_fault;
        logic hiccup_fault;
        normal = state_q inside {PSS_BIAS_RAMP, PSS_FREQ_CHECK, PSS_BIAS_READY,
                                 PSS_PRIMARY_RAMP, PSS_PRIMARY_ON, PSS_SERVO};
        bias_fault = events_i.bias_converter_fault || events_i.aux_undervoltage_fault
                     || events_i.freq_resistor_out_of_range || events_i.hard_thermal_shutdown;
        // in auto-restart a falling internal enable is that state's own exit to bias ready
        latch_fault = (int_en_fall && state_q != PSS_AUTO_RESTART)
                      || events_i.latch_undervoltage_fault
                      || events_i.latch_sync_error || events_i.output_overvoltage_fault
                      || events_i.output_overcurrent_fault;
        hiccup_fault = events_i.hiccup_undervoltage_fault || events_i.hiccup_sync_error
                       || events_i.soft_thermal_shutdown;
        state_d = state_q;
        if (!events_i.power_present || events_i.input_undervoltage_lockout
            || events_i.input_overvoltage_lockout) begin
            state_d = PSS_NO_POWER;
        end else if (normal && bias_fault) begin
            state_d = PSS_BIAS_RESET;
        end else if (enable_i && latch_fault && state_q != PSS_SHUTDOWN
                     && state_q != PSS_BIAS_RESET && state_q != PSS_NO_POWER) begin
            state_d = PSS_SHUTDOWN;
        end else if (enable_i && hiccup_fault && state_q != PSS_AUTO_RESTART
                     && state_q != PSS_SHUTDOWN && state_q != PSS_BIAS_RESET
                     && state_q != PSS_NO_POWER) begin
            state_d = PSS_AUTO_RESTART;
        end else begin
            unique case (state_q)
                PSS_NO_POWER: state_d = PSS_BIAS_RAMP;
                PSS_BIAS_RAMP: begin
                    if (events_i.bias_converter_up) state_d = PSS_FREQ_CHECK;
                end
                PSS_FREQ_CHECK: begin
                    if (events_i.freq_resistor_valid) state_d = PSS_BIAS_READY;
                end
                PSS_BIAS_READY: begin
                    if (en_rise) state_d = PSS_PRIMARY_RAMP;
                end
                PSS_PRIMARY_RAMP: begin
                    if (out_rise) state_d = PSS_PRIMARY_ON;
                end
                PSS_PRIMARY_ON: begin
                    if (target_change_i) state_d = PSS_SERVO;
                end
                PSS_SERVO: begin
                    if (events_i.servo_complete) state_d = PSS_PRIMARY_ON;
                end
                PSS_BIAS_RESET: begin
                    if (reset_done) state_d = PSS_BIAS_RAMP;
                end
                PSS_SHUTDOWN: begin
                    if (events_i.shutdown_complete) state_d = PSS_BIAS_READY;
                end
                PSS_AUTO_RESTART: begin
                    if (int_en_fall) state_d = PSS_BIAS_READY;
                    else if (hiccup_done) state_d = PSS_PRIMARY_RAMP;
                end
                default: state_d = PSS_NO_POWER;
            endcase
        end
    end

    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            state_q <= PSS_NO_POWER;
            en_q <= 1'b0;
            int_en_q <= 1'b0;
            out_q <= 1'b0;
        end else begin
            state_q <= state_d;
            en_q <= enable_i;
            int_en_q <= internal_converter_enable_i;
            out_q <= events_i.output_rising;
        end
    end

    // bias-good holds from bias ready through all primary states
    assign bias_good = state_q inside {PSS_BIAS_READY, PSS_PRIMARY_RAMP, PSS_PRIMARY_ON,
                                       PSS_SERVO, PSS_SHUTDOWN, PSS_AUTO_RESTART};

    // register port: ignored entirely until bias-good, bit 0 always reads zero
    always_comb begin
        cfg_d = cfg_q;
        rdata_d = rdata_q;
        ack_d = 1'b0;
        if (bias_good && (reg_wr_i || reg_rd_i)) begin
            ack_d = 1'b1;
            if (reg_addr_i == PSS_CFG_ADDR) begin
                if (reg_wr_i) begin
                    cfg_d = reg_wdata_i & PSS_CFG_WMASK;
                end
                rdata_d = cfg_q;
            end else begin
                rdata_d = 8'h00; // other addresses live outside this block
            end
        end
    end

    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            cfg_q <= PSS_CFG_RESET;
            rdata_q <= 8'h00;
            ack_q <= 1'b0;
        end else begin
            cfg_q <= cfg_d;
            rdata_q <= rdata_d;
            ack_q <= ack_d;
        end
    end

    // outputs
    assign reg_rdata_o = rdata_q;
    assign reg_ack_o = ack_q;
    assign state_o = state_q;
    assign bias_good_indicator_o = bias_good;
    assign output_good_indicator_o = state_q == PSS_PRIMARY_ON;
    assign primary_enable_o = state_q inside {PSS_PRIMARY_RAMP, PSS_PRIMARY_ON, PSS_SERVO};
    assign bias_cfg_o.full_duty = cfg_q[PSS_FULL_DUTY_BIT];
    assign bias_cfg_o.spread_spectrum = cfg_q[PSS_SPREAD_BIT];
    assign bias_cfg_o.continuous_conduction = cfg_q[PSS_CONT_COND_BIT];
    assign bias_cfg_o.high_side_drive_strength =
        pss_drive(cfg_q[PSS_HIGH_DRV_MSB:PSS_HIGH_DRV_LSB]);
    assign bias_cfg_o.low_side_drive_strength =
        pss_drive(cfg_q[PSS_LOW_DRV_MSB:PSS_LOW_DRV_LSB]);
endmodule // pss_sequencer

// ---- pss_sequencer_assertions.sv ----
// port-level checker of the power state sequencer
// assumes a bind onto pss_sequencer; one clock, async active-low reset
`timescale 1ns/100ps
module pss_seq_chk
    import pss_pkg::*;
#(
    parameter int RESET_DELAY_CYC = 4,
    parameter int HICCUP_CYC = 8
) (
    // clock and reset
    input wire logic clock_i,
    input wire logic rst_n_i,
    // watched inputs
    input wire pss_events_t events_i,
    input wire logic enable_i,
    input wire logic internal_converter_enable_i,
    input wire logic target_change_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    input wire logic [7:0] reg_addr_i,
    input wire logic [7:0] reg_wdata_i,
    // watched outputs
    input wire logic reg_ack_o,
    input wire pss_state_t state_o,
    input wire logic bias_good_indicator_o,
    input wire pss_bias_cfg_t bias_cfg_o
);
    // cause groups, named by the priority level they belong to
    wire pss_events_t ev = events_i;
    wire logic pwr_ok = ev.power_present & ~ev.input_undervoltage_lockout
        & ~ev.input_overvoltage_lockout;
    wire logic bias_f = ev.freq_resistor_out_of_range | ev.bias_converter_fault
        | ev.aux_undervoltage_fault | ev.hard_thermal_shutdown;
    wire logic latch_f = ev.latch_undervoltage_fault | ev.latch_sync_error
        | ev.output_overvoltage_fault | ev.output_overcurrent_fault;
    wire logic hic_f = ev.hiccup_undervoltage_fault | ev.hiccup_sync_error
        | ev.soft_thermal_shutdown;
    wire logic normal = state_o inside {PSS_BIAS_RAMP, PSS_FREQ_CHECK, PSS_BIAS_READY,
        PSS_PRIMARY_RAMP, PSS_PRIMARY_ON, PSS_SERVO};
    wire logic [6:0] wfield = reg_wdata_i[7:1];
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (!rst_n_i);
    // no higher-priority cause, so only a normal move may happen
    sequence quiet;
        pwr_ok && !bias_f && !(enable_i && (latch_f || hic_f
            || $fell(internal_converter_enable_i)));
    endsequence
    chk_power_loss: assert property (!pwr_ok |=> state_o == PSS_NO_POWER)
        else $error("no-power state missed");
    chk_bias_fault: assert property (pwr_ok && bias_f && normal |=> state_o == PSS_BIAS_RESET)
        else $error("bias reset missed");
    chk_ramp_up: assert property (quiet ##0 (state_o == PSS_BIAS_RAMP
        && ev.bias_converter_up) |=> state_o == PSS_FREQ_CHECK) else $error("ramp exit");
    chk_freq_ok: assert property (quiet ##0 (state_o == PSS_FREQ_CHECK
        && ev.freq_resistor_valid) |=> state_o == PSS_BIAS_READY) else $error("check exit");
    chk_enable_go: assert property (quiet ##0 (state_o == PSS_BIAS_READY
        && $rose(enable_i)) |=> state_o == PSS_PRIMARY_RAMP) else $error("enable start");
    chk_servo_in: assert property (quiet ##0 (state_o == PSS_PRIMARY_ON
        && target_change_i) |=> state_o == PSS_SERVO) else $error("servo entry");
    chk_servo_done: assert property (quiet ##0 (state_o == PSS_SERVO
        && ev.servo_complete) |=> state_o == PSS_PRIMARY_ON) else $error("servo exit");
    chk_latch_off: assert property (pwr_ok && !(bias_f && normal) && enable_i && latch_f
        && state_o != PSS_NO_POWER && state_o != PSS_BIAS_RESET
        |=> state_o == PSS_SHUTDOWN) else $error("shutdown missed");
    chk_ramp_done: assert property (quiet ##0 (state_o == PSS_PRIMARY_RAMP
        && $rose(ev.output_rising)) |=> state_o == PSS_PRIMARY_ON) else $error("ramp end");
    chk_restart_exit: assert property (pwr_ok && !(enable_i && latch_f)
        && state_o == PSS_AUTO_RESTART && $fell(internal_converter_enable_i)
        |=> state_o == PSS_BIAS_READY) else $error("restart exit missed");
    chk_reg_gate: assert property ((reg_wr_i || reg_rd_i)
        |=> reg_ack_o == $past(bias_good_indicator_o)) else $error("ack gating wrong");
    chk_cfg_write: assert property (reg_wr_i && bias_good_indicator_o
        && reg_addr_i == PSS_CFG_ADDR && wfield[3:2] inside {2'h0, 2'h3}
        && wfield[1:0] inside {2'h0, 2'h3} |=> bias_cfg_o == $past(wfield))
        else $error("config byte not taken");
endmodule // pss_seq_chk

// ---- pss_supervisor_model.sv ----
// analog supervisor model: answers the ramp, check, servo and shutdown states after a prompt or slow delay
// assumes the bench injects faults by flipping event bits through inj_i
`timescale 1ns/100ps
module pss_supervisor_model
    import pss_pkg::*;
(
    // clock and reset
    input wire logic clock_i,
    input wire logic rst_n_i,
    // control
    input wire pss_state_t state_i,
    input wire logic slow_i,
    input wire pss_events_t inj_i,
    // events
    output pss_events_t events_o
);
    pss_state_t last_q;
    int cnt_q;
    // the count is stale in the first cycle of a new state, so that cycle is never ready
    wire logic rdy = state_i == last_q && cnt_q >= (slow_i ? 6 : 1);
    // cycles spent in the current state
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            last_q <= PSS_NO_POWER;
            cnt_q <= 0;
        end else begin
            last_q <= state_i;
            cnt_q <= (state_i == last_q) ? cnt_q + 1 : 0;
        end
    end
    // each stage reports done only after its delay; xor lets a fault drop power too
    always_comb begin
        events_o = '0;
        events_o.power_present = 1'b1;
        events_o.bias_converter_up = state_i == PSS_BIAS_RAMP && rdy;
        events_o.freq_resistor_valid = state_i == PSS_FREQ_CHECK && rdy;
        events_o.output_rising = (state_i == PSS_PRIMARY_RAMP && rdy)
            || state_i inside {PSS_PRIMARY_ON, PSS_SERVO};
        events_o.servo_complete = state_i == PSS_SERVO && rdy;
        events_o.shutdown_complete = state_i == PSS_SHUTDOWN && rdy;
        events_o = events_o ^ inj_i;
    end
endmodule // pss_supervisor_model

// ---- tb_pss_sequencer.sv ----
// self-checking bench for the power state sequencer
// assumes the supervisor model; short delay values keep the run brief
`timescale 1ns/100ps
`define CHK(n, e, g) begin n_tests++; if ((g) !== (e)) begin bad_count++; \
    $display("[ERR] %s exp %h got %h", n, e, g); end end
module tb_pss_sequencer;
    import pss_pkg::*;
    localparam int RD = 4;
    localparam int HC = 8;
    logic clock_i = 1'b0;
    logic rst_n_i = 1'b0;
    logic enable_i = 1'b0;
    logic internal_converter_enable_i = 1'b1;
    logic target_change_i = 1'b0;
    logic reg_wr_i = 1'b0;
    logic reg_rd_i = 1'b0;
    logic [7:0] reg_addr_i = 8'h00;
    logic [7:0] reg_wdata_i = 8'h00;
    logic slow = 1'b1;
    pss_events_t events_i, f;
    pss_events_t inj = '0;
    logic [7:0] reg_rdata_o, rd, w;
    logic reg_ack_o, k, bias_good_indicator_o, output_good_indicator_o, primary_enable_o;
    pss_state_t state_o;
    pss_bias_cfg_t bias_cfg_o;
    int bad_count = 0;
    int n_tests = 0;
    int seed = 32'h1e8f19dc;
    int n;
    initial forever #12.5 clock_i = ~clock_i;
    pss_sequencer #(.RESET_DELAY_CYC(RD), .HICCUP_CYC(HC)) pss_sequencer_i (.clock_i,
        .rst_n_i, .events_i, .enable_i, .internal_converter_enable_i, .target_change_i,
        .reg_wr_i, .reg_rd_i, .reg_addr_i, .reg_wdata_i, .reg_rdata_o, .reg_ack_o, .state_o,
        .bias_good_indicator_o, .output_good_indicator_o, .primary_enable_o, .bias_cfg_o);
    pss_supervisor_model pss_supervisor_model_i (.clock_i, .rst_n_i, .state_i(state_o),
        .slow_i(slow), .inj_i(inj), .events_o(events_i));
    function automatic logic [7:0] cfg_of(input logic [7:0] v);
        return v & PSS_CFG_WMASK;
    endfunction
    // one-cycle strobe; ack and data are registered, so look one cycle later
    task automatic acc(input logic wr, input logic [7:0] a, input logic [7:0] d);
        @(negedge clock_i);
        reg_wr_i = wr;
        reg_rd_i = !wr;
        reg_addr_i = a;
        reg_wdata_i = d;
        @(negedge clock_i);
        reg_wr_i = 1'b0;
        reg_rd_i = 1'b0;
        rd = reg_rdata_o;
        k = reg_ack_o;
    endtask
    task automatic go(input pss_state_t s);
        for (n = 0; n < 300 && state_o !== s; n++) @(negedge clock_i);
        `CHK("state", s, state_o)
    endtask
    task automatic stay(input pss_state_t s, input int exp_n);
        for (n = 0; n < 300 && state_o === s; n++) @(negedge clock_i);
        `CHK("cycles", exp_n, n)
    endtask
    task automatic pulse(input pss_events_t e);
        @(negedge clock_i);
        inj = e;
        @(negedge clock_i);
        inj = '0;
    endtask
    task automatic final_report;
        $display("checks %0d mismatches %0d", n_tests, bad_count);
        if (bad_count == 0 && n_tests > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    // the walk below needs well under a thousand cycles
    initial begin
        repeat (5000) @(posedge clock_i);
        bad_count++;
        final_report;
    end
    initial begin
        repeat (6) @(posedge clock_i);
        `CHK("reset state", PSS_NO_POWER, state_o)
        `CHK("reset cfg", PSS_CFG_RESET[7:1], bias_cfg_o)
        @(negedge clock_i);
        rst_n_i = 1'b1;
        acc(1'b0, PSS_CFG_ADDR, 8'h00);
        `CHK("early ack", 1'b0, k)
        go(PSS_FREQ_CHECK);
        go(PSS_BIAS_READY);
        `CHK("bias good", 1'b1, bias_good_indicator_o)
        acc(1'b0, PSS_CFG_ADDR, 8'h00);
        `CHK("cfg read", PSS_CFG_RESET, rd)
        // random legal bytes; drive fields are only ever written 00 or 11
        repeat (10) begin
            w = 8'($random(seed));
            w[4:3] = {2{w[3]}};
            w[2:1] = {2{w[1]}};
            acc(1'b1, PSS_CFG_ADDR, w);
            `CHK("cfg out", cfg_of(w), {bias_cfg_o, 1'b0})
            acc(1'b0, PSS_CFG_ADDR, 8'h00);
            `CHK("cfg back", cfg_of(w), rd)
        end
        acc(1'b0, 8'h0e, 8'h00);
        `CHK("other ack", 1'b1, k)
        `CHK("other data", 8'h00, rd)
        $display("test registers done");
        slow = 1'($random(seed));
        enable_i = 1'b1;
        go(PSS_PRIMARY_RAMP);
        `CHK("primary en", 1'b1, primary_enable_o)
        go(PSS_PRIMARY_ON);
        `CHK("out good", 1'b1, output_good_indicator_o)
        target_change_i = 1'b1;
        @(negedge clock_i);
        target_change_i = 1'b0;
        go(PSS_SERVO);
        `CHK("servo good", 1'b0, output_good_indicator_o)
        go(PSS_PRIMARY_ON);
        $display("test normal walk done");
        f = '0;
        f.output_overcurrent_fault = 1'b1;
        pulse(f);
        go(PSS_SHUTDOWN);
        go(PSS_BIAS_READY);
        enable_i = 1'b0;
        @(negedge clock_i);
        enable_i = 1'b1;
        go(PSS_PRIMARY_ON);
        f = '0;
        f.soft_thermal_shutdown = 1'b1;
        pulse(f);
        go(PSS_AUTO_RESTART);
        stay(PSS_AUTO_RESTART, HC + 1);
        go(PSS_PRIMARY_RAMP);
        go(PSS_PRIMARY_ON);
        f = '0;
        f.hiccup_sync_error = 1'b1;
        pulse(f);
        go(PSS_AUTO_RESTART);
        internal_converter_enable_i = 1'b0;
        @(negedge clock_i);
        `CHK("restart exit", PSS_BIAS_READY, state_o)
        internal_converter_enable_i = 1'b1;
        enable_i = 1'b0;
        @(negedge clock_i);
        enable_i = 1'b1;
        go(PSS_PRIMARY_ON);
        internal_converter_enable_i = 1'b0;
        @(negedge clock_i);
        `CHK("int enable off", PSS_SHUTDOWN, state_o)
        internal_converter_enable_i = 1'b1;
        go(PSS_BIAS_READY);
        f.bias_converter_fault = 1'b1;
        f.output_overcurrent_fault = 1'b1;
        pulse(f);
        go(PSS_BIAS_RESET);
        stay(PSS_BIAS_RESET, RD + 1);
        go(PSS_BIAS_READY);
        f.power_present = 1'b1;
        pulse(f);
        go(PSS_NO_POWER);
        go(PSS_BIAS_RAMP);
        $display("test protection done");
        final_report;
    end
endmodule // tb_pss_sequencer
bind pss_sequencer pss_seq_chk #(.RESET_DELAY_CYC(RESET_DELAY_CYC), .HICCUP_CYC(HICCUP_CYC))
    pss_seq_chk_i (.clock_i, .rst_n_i, .events_i, .enable_i, .internal_converter_enable_i,
    .target_change_i, .reg_wr_i, .reg_rd_i, .reg_addr_i, .reg_wdata_i, .reg_ack_o,
    .state_o, .bias_good_indicator_o, .bias_cfg_o);
